// file: design/irq_flag_regs.sv
// Module: request flags, enables and priorities behind an Avalon-MM slave
//
// How it works
// - One flag register holds 32 flags, one per source, bits 31 to 0.
// - A flag reads 1 after its source requested, else 0; software may write it.
// - One enable register holds 32 bits; 1 lets the source interrupt, 0 blocks.
// - Each source has a 3-bit priority, codes 1 to 7 give levels 1 to 7.
// - Priority code 0 disables the source whatever its subpriority.
// - Each source has a 2-bit subpriority, codes 0 to 3 give levels 0 to 3.
// - Priority registers pack four sources, one per byte, priority 4:2, sub 1:0.
// - Top three bits of each priority byte read zero and ignore writes.
`default_nettype none

module irq_flag_regs #(
  parameter int NUM_SRC = irq_regs_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [irq_regs_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [irq_regs_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [irq_regs_pkg::BE_W-1:0] avs_byteenable_i,
  output logic [irq_regs_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Peripheral event pulses, same clock
  input wire logic [NUM_SRC-1:0] src_event_i,
  // Toward the core
  output logic [NUM_SRC-1:0] src_request_o,
  output irq_regs_pkg::core_req_s core_req_o,
  // Block interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Only word-aligned offsets decode; a stray byte address counts as unmapped
  function automatic logic is_prio(input logic [irq_regs_pkg::ADDR_W-1:0] a);
    logic in_range;
    in_range = a >= irq_regs_pkg::OFS_PRIO_BASE && a <= irq_regs_pkg::OFS_PRIO_END;
    return in_range && a[1:0] == 2'h0;
  endfunction : is_prio

  function automatic logic is_mapped(input logic [irq_regs_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = is_prio(a);
    case (a)
      irq_regs_pkg::OFS_REQUEST_FLAG,
      irq_regs_pkg::OFS_SOURCE_ENABLE,
      irq_regs_pkg::OFS_PENDING,
      irq_regs_pkg::OFS_CORE_STAT,
      irq_regs_pkg::OFS_EVT_STAT,
      irq_regs_pkg::OFS_EVT_MASK: hit = 1'b1;
      default: hit = hit;
    endcase
    return hit;
  endfunction : is_mapped

  // Byte-lane merge of write data over the old value
  function automatic logic [irq_regs_pkg::DATA_W-1:0] merge_be(
    input logic [irq_regs_pkg::DATA_W-1:0] old_v,
    input logic [irq_regs_pkg::DATA_W-1:0] new_v,
    input logic [irq_regs_pkg::BE_W-1:0] be
  );
    logic [irq_regs_pkg::DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < irq_regs_pkg::BE_W; b++) begin
      if (be[b]) begin
        res[b*irq_regs_pkg::BYTE_W +: irq_regs_pkg::BYTE_W] =
          new_v[b*irq_regs_pkg::BYTE_W +: irq_regs_pkg::BYTE_W];
      end
    end
    return res;
  endfunction : merge_be

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  irq_regs_pkg::bus_state_e state_ff;
  logic [irq_regs_pkg::DATA_W-1:0] readdata_ff;
  logic wait_ff;
  logic [NUM_SRC-1:0] flag_ff;
  logic [NUM_SRC-1:0] enable_ff;
  logic [NUM_SRC-1:0][irq_regs_pkg::LVL_W-1:0] level_ff;
  logic [NUM_SRC-1:0][irq_regs_pkg::SUB_W-1:0] sub_ff;
  logic [irq_regs_pkg::NUM_EVT-1:0] evt_stat_ff;
  logic [irq_regs_pkg::NUM_EVT-1:0] evt_mask_ff;
  logic [NUM_SRC-1:0] request_ff;
  irq_regs_pkg::core_req_s core_req_ff;
  logic irq_ff;

  logic fire;
  logic wr_fire;
  logic [NUM_SRC-1:0] forward;
  logic [NUM_SRC-1:0] nxt_flag;
  logic [NUM_SRC-1:0] nxt_enable;
  logic [irq_regs_pkg::NUM_EVT-1:0] evt_set;
  logic [irq_regs_pkg::NUM_EVT-1:0] evt_clr;
  logic [irq_regs_pkg::DATA_W-1:0] nxt_readdata;
  logic [irq_regs_pkg::DATA_W-1:0] prio_word;
  logic [irq_regs_pkg::ADDR_W-1:0] prio_ofs;
  logic [2:0] prio_sel;
  irq_regs_pkg::core_req_s winner;
  logic wr_flag;
  logic wr_enable;
  logic wr_prio;
  logic wr_evt_stat;
  logic wr_evt_mask;
  logic rd_take;
  logic bad_addr;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data off a combinational path
  assign fire = state_ff == irq_regs_pkg::BUS_ANSWER;
  assign wr_fire = fire && avs_write_i;

  // Decoded once so every register sees the same accepted access
  assign wr_flag = wr_fire && avs_address_i == irq_regs_pkg::OFS_REQUEST_FLAG;
  assign wr_enable = wr_fire && avs_address_i == irq_regs_pkg::OFS_SOURCE_ENABLE;
  assign wr_prio = wr_fire && is_prio(avs_address_i);
  assign wr_evt_stat = wr_fire && avs_address_i == irq_regs_pkg::OFS_EVT_STAT &&
                       avs_byteenable_i[0];
  assign wr_evt_mask = wr_fire && avs_address_i == irq_regs_pkg::OFS_EVT_MASK &&
                       avs_byteenable_i[0];
  assign rd_take = state_ff == irq_regs_pkg::BUS_IDLE && avs_read_i;
  assign bad_addr = fire && !is_mapped(avs_address_i);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= irq_regs_pkg::BUS_IDLE;
      wait_ff <= 1'b1;
    end else begin
      case (state_ff)
        irq_regs_pkg::BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            state_ff <= irq_regs_pkg::BUS_ANSWER;
            wait_ff <= 1'b0;
          end
        end
        irq_regs_pkg::BUS_ANSWER: begin
          state_ff <= irq_regs_pkg::BUS_IDLE;
          wait_ff <= 1'b1;
        end
        default: begin
          state_ff <= irq_regs_pkg::BUS_IDLE;
          wait_ff <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  // A source event in the clearing cycle still sets the flag
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_flag) begin
      nxt_flag = merge_be(flag_ff, avs_writedata_i, avs_byteenable_i);
    end
    nxt_flag = nxt_flag | src_event_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      flag_ff <= irq_regs_pkg::REQUEST_FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ----------------------------------------------------------------
  // Source enables
  // ----------------------------------------------------------------
  always_comb begin
    nxt_enable = enable_ff;
    if (wr_enable) begin
      nxt_enable = merge_be(enable_ff, avs_writedata_i, avs_byteenable_i);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      enable_ff <= irq_regs_pkg::SOURCE_ENABLE_RST;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // ----------------------------------------------------------------
  // Priority fields
  // ----------------------------------------------------------------
  assign prio_ofs = avs_address_i - irq_regs_pkg::OFS_PRIO_BASE;
  assign prio_sel = prio_ofs[4:2];

  for (genvar g = 0; g < NUM_SRC; g++) begin : g_prio
    localparam int REG_IDX = g / irq_regs_pkg::SRC_PER_PRIO;
    localparam int LANE = g % irq_regs_pkg::SRC_PER_PRIO;
    localparam int BASE = LANE * irq_regs_pkg::BYTE_W;

    // Bits 7:5 of the lane have no storage
    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        level_ff[g] <= irq_regs_pkg::LVL_RST;
        sub_ff[g] <= irq_regs_pkg::SUB_RST;
      end else if (wr_prio &&
                   32'(prio_sel) == REG_IDX && avs_byteenable_i[LANE]) begin
        level_ff[g] <= avs_writedata_i[BASE+irq_regs_pkg::LVL_LSB +: irq_regs_pkg::LVL_W];
        sub_ff[g] <= avs_writedata_i[BASE+irq_regs_pkg::SUB_LSB +: irq_regs_pkg::SUB_W];
      end
    end
  end

  // Pack four sources per word; unimplemented bits stay zero
  always_comb begin
    prio_word = '0;
    for (int l = 0; l < irq_regs_pkg::SRC_PER_PRIO; l++) begin
      prio_word[l*irq_regs_pkg::BYTE_W+irq_regs_pkg::LVL_LSB +: irq_regs_pkg::LVL_W] =
        level_ff[prio_sel*irq_regs_pkg::SRC_PER_PRIO+l];
      prio_word[l*irq_regs_pkg::BYTE_W+irq_regs_pkg::SUB_LSB +: irq_regs_pkg::SUB_W] =
        sub_ff[prio_sel*irq_regs_pkg::SRC_PER_PRIO+l];
    end
    for (int l = 0; l < irq_regs_pkg::SRC_PER_PRIO; l++) begin
      prio_word[l*irq_regs_pkg::BYTE_W +: irq_regs_pkg::BYTE_W] =
        prio_word[l*irq_regs_pkg::BYTE_W +: irq_regs_pkg::BYTE_W] &
        irq_regs_pkg::PRIO_BYTE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Forwarding to the core
  // ----------------------------------------------------------------
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_fwd
    assign forward[s] = flag_ff[s] && enable_ff[s] &&
                        level_ff[s] != irq_regs_pkg::LVL_OFF;
  end

  irq_pick #(
    .N(NUM_SRC),
    .IDX_W(irq_regs_pkg::SRC_IDX_W)
  ) u_pick (
    .active_i(forward),
    .level_i(level_ff),
    .sub_i(sub_ff),
    .win_o(winner)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      request_ff <= '0;
      core_req_ff <= '0;
    end else begin
      request_ff <= forward;
      core_req_ff <= winner;
    end
  end

  // ----------------------------------------------------------------
  // Block events, mask and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[irq_regs_pkg::EVT_NEW_REQ] = |(src_event_i & ~flag_ff);
    evt_set[irq_regs_pkg::EVT_BAD_ADDR] = bad_addr;
    evt_clr = '0;
    if (wr_evt_stat) begin
      evt_clr = avs_writedata_i[irq_regs_pkg::NUM_EVT-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      evt_stat_ff <= irq_regs_pkg::EVT_RST;
    end else begin
      evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      evt_mask_ff <= irq_regs_pkg::EVT_RST;
    end else if (wr_evt_mask) begin
      evt_mask_ff <= avs_writedata_i[irq_regs_pkg::NUM_EVT-1:0];
    end
  end

  // Level output lags the status bits by one clock
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_stat_ff & evt_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_readdata = '0;
    if (is_prio(avs_address_i)) begin
      nxt_readdata = prio_word;
    end else begin
      case (avs_address_i)
        irq_regs_pkg::OFS_REQUEST_FLAG: nxt_readdata = flag_ff;
        irq_regs_pkg::OFS_SOURCE_ENABLE: nxt_readdata = enable_ff;
        irq_regs_pkg::OFS_PENDING: nxt_readdata = request_ff;
        irq_regs_pkg::OFS_CORE_STAT: begin
          nxt_readdata[irq_regs_pkg::CSTAT_SRC_LSB +: irq_regs_pkg::SRC_IDX_W] =
            core_req_ff.source;
          nxt_readdata[irq_regs_pkg::CSTAT_LVL_LSB +: irq_regs_pkg::LVL_W] = core_req_ff.level;
          nxt_readdata[irq_regs_pkg::CSTAT_SUB_LSB +: irq_regs_pkg::SUB_W] = core_req_ff.sub;
          nxt_readdata[irq_regs_pkg::CSTAT_VALID] = core_req_ff.valid;
        end
        irq_regs_pkg::OFS_EVT_STAT: nxt_readdata[irq_regs_pkg::NUM_EVT-1:0] = evt_stat_ff;
        irq_regs_pkg::OFS_EVT_MASK: nxt_readdata[irq_regs_pkg::NUM_EVT-1:0] = evt_mask_ff;
        default: nxt_readdata = '0;
      endcase
    end
  end

  // Captured as the request is accepted; stands through the answer cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      readdata_ff <= '0;
    end else if (rd_take) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata_o = readdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign src_request_o = request_ff;
  assign core_req_o = core_req_ff;
  assign irq_o = irq_ff;

endmodule : irq_flag_regs

`default_nettype wire

// file: design/irq_pick.sv
// Module: picks the highest priority forwarded source for the core
`default_nettype none

module irq_pick #(
  parameter int N = 32,
  parameter int IDX_W = 5
) (
  // Candidates
  input wire logic [N-1:0] active_i,
  input wire logic [N-1:0][irq_regs_pkg::LVL_W-1:0] level_i,
  input wire logic [N-1:0][irq_regs_pkg::SUB_W-1:0] sub_i,
  // Winner
  output irq_regs_pkg::core_req_s win_o
);

  localparam int KEY_W = irq_regs_pkg::LVL_W + irq_regs_pkg::SUB_W;

  logic [KEY_W-1:0] best_key;
  logic [KEY_W-1:0] key;

  // Strict compare: equal keys keep the lowest source number
  always_comb begin
    best_key = '0;
    key = '0;
    win_o = '0;
    for (int i = 0; i < N; i++) begin
      key = {level_i[i], sub_i[i]};
      if (active_i[i] && (!win_o.valid || key > best_key)) begin
        best_key = key;
        win_o.valid = 1'b1;
        win_o.level = level_i[i];
        win_o.sub = sub_i[i];
        win_o.source = IDX_W'(i);
      end
    end
  end

endmodule : irq_pick

`default_nettype wire

// file: pkg/irq_regs_pkg.sv
// Package: register map, field layout and carriers of the interrupt bookkeeping block
`default_nettype none

package irq_regs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int NUM_SRC = 32;
  localparam int SRC_IDX_W = 5;
  localparam int LVL_W = 3;
  localparam int SUB_W = 2;
  localparam int SRC_PER_PRIO = 4;
  localparam int NUM_PRIO_REGS = NUM_SRC / SRC_PER_PRIO;
  localparam int NUM_EVT = 2;

  // ----------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_REQUEST_FLAG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CORE_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PRIO_END = 8'h3C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SUB_LSB = 0;
  localparam int LVL_LSB = 2;
  localparam logic [BYTE_W-1:0] PRIO_BYTE_MASK = 8'h1F;
  localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
  localparam int EVT_NEW_REQ = 0;
  localparam int EVT_BAD_ADDR = 1;
  localparam int CSTAT_SRC_LSB = 0;
  localparam int CSTAT_LVL_LSB = 8;
  localparam int CSTAT_SUB_LSB = 12;
  localparam int CSTAT_VALID = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REQUEST_FLAG_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SOURCE_ENABLE_RST = 32'h0000_0000;
  localparam logic [LVL_W-1:0] LVL_RST = 3'h0;
  localparam logic [SUB_W-1:0] SUB_RST = 2'h0;
  localparam logic [NUM_EVT-1:0] EVT_RST = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

  typedef struct packed {
    logic valid;
    logic [LVL_W-1:0] level;
    logic [SUB_W-1:0] sub;
    logic [SRC_IDX_W-1:0] source;
  } core_req_s;

endpackage : irq_regs_pkg

`default_nettype wire

// file: test/core_model.sv
// Partner: processor core that takes the presented interrupt request
`default_nettype none

module core_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // From the block
  input wire irq_regs_pkg::core_req_s req_i,
  // Last request taken
  output irq_regs_pkg::core_req_s taken_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Keeps the last valid request so a short-lived one is not missed
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) taken_o <= '0;
    else if (req_i.valid) taken_o <= req_i;
  end
endmodule : core_model

`default_nettype wire

// file: test/irq_flag_regs_sva.sv
// Checker: port-level assertions for the interrupt bookkeeping block
`default_nettype none

module irq_flag_regs_sva #(
  parameter int NUM_SRC = 32
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic [irq_regs_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [irq_regs_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Toward the core
  input wire logic [NUM_SRC-1:0] src_request_o,
  input wire irq_regs_pkg::core_req_s core_req_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  AST_WAIT_IDLE: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest dropped without a request");
  AST_WAIT_ACCEPT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one wait cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  // ----------------------------------------------------------------
  // Fields and forwarding
  // ----------------------------------------------------------------
  AST_PRIO_TOP_ZERO: assert property (
    !avs_waitrequest_o && avs_read_i && avs_address_i >= 8'h20 && avs_address_i <= 8'h3C
    |-> (avs_readdata_o & 32'hE0E0_E0E0) == 32'h0000_0000)
    else $error("unimplemented priority bits read nonzero");
  AST_CORE_VALID: assert property (core_req_o.valid == (src_request_o != '0))
    else $error("core request valid disagrees with forwarded sources");
  AST_CORE_SRC: assert property (core_req_o.valid |-> src_request_o[core_req_o.source])
    else $error("core request names a source that is not forwarded");
  AST_CORE_LVL: assert property (core_req_o.valid |-> core_req_o.level != 3'h0)
    else $error("core request with priority zero");
  AST_CORE_NONE: assert property (!core_req_o.valid |-> core_req_o == 11'h000)
    else $error("idle core request not all zero");
endmodule : irq_flag_regs_sva

bind irq_flag_regs irq_flag_regs_sva #(.NUM_SRC(NUM_SRC)) u_sva (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .src_request_o(src_request_o),
  .core_req_o(core_req_o)
);

`default_nettype wire

// file: test/tb.sv
// Testbench: register, forwarding and interrupt scenarios for the bookkeeping block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [31:0] ev = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_req;
  logic [31:0] fwd;
  irq_regs_pkg::core_req_s core_req;
  irq_regs_pkg::core_req_s taken;
  logic irq;
  int fail_count = 0;
  int checked = 0;

  irq_flag_regs #(.NUM_SRC(32)) dut (.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .src_event_i(ev),
    .src_request_o(fwd), .core_req_o(core_req), .irq_o(irq));
  core_model u_core (.sys_clk_i(clk), .rst_n_i(rst_n), .req_i(core_req), .taken_o(taken));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One access; waits for waitrequest low, then releases after that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    be <= b;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk("waitrequest", 32'h0, 32'h1);
      finish_test();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr32

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, exp, q);
  endtask : rd_chk

  task automatic pulse(input logic [31:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 32'h0000_0000;
    repeat (3) @(posedge clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rd_chk("flags", 8'h00, 32'h0000_0000);
    rd_chk("enables", 8'h04, 32'h0000_0000);
    for (int k = 0; k < 8; k++) rd_chk("prio", 8'(8'h20 + 4 * k), 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask : test_reset

  task automatic test_regs();
    logic [31:0] q;
    pulse(32'h8000_0008);
    rd_chk("flags set", 8'h00, 32'h8000_0008);
    wr32(8'h00, 32'h0000_0000);
    rd_chk("flags clear", 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'hFFFF_FFFF, 4'h2, q);
    rd_chk("flags lane", 8'h00, 32'h0000_FF00);
    wr32(8'h04, 32'hA5A5_A5A5);
    rd_chk("enables", 8'h04, 32'hA5A5_A5A5);
    for (int k = 0; k < 8; k++) begin
      wr32(8'(8'h20 + 4 * k), 32'hFFFF_FFFF);
      rd_chk("prio mask", 8'(8'h20 + 4 * k), 32'h1F1F_1F1F);
    end
    wr32(8'h20, 32'h0015_0000);
    rd_chk("prio field", 8'h20, 32'h0015_0000);
    $display("test regs done");
  endtask : test_regs

  task automatic test_levels();
    logic [31:0] exp;
    wr32(8'h00, 32'h0000_0001);
    wr32(8'h04, 32'h0000_0001);
    for (int l = 0; l < 8; l++) begin
      wr32(8'h20, 32'(l * 4 + l % 4));
      repeat (2) @(posedge clk);
      exp = {21'h0, (l != 0), 3'(l), 2'(l % 4), 5'h00};
      chk("core level", exp, {21'h0, core_req});
      chk("forward", {31'h0, (l != 0)}, fwd);
    end
    wr32(8'h20, 32'h0000_0003);
    rd_chk("pending sub only", 8'h08, 32'h0000_0000);
    $display("test levels done");
  endtask : test_levels

  task automatic test_forward();
    wr32(8'h00, 32'h0000_0000);
    wr32(8'h20, 32'h0015_0000);
    wr32(8'h28, 32'h0000_1C00);
    wr32(8'h04, 32'h0000_0204);
    pulse(32'h0000_0004);
    chk("fwd one", 32'h0000_0004, fwd);
    chk("core one", {21'h0, 1'b1, 3'h5, 2'h1, 5'h02}, {21'h0, core_req});
    pulse(32'h0000_0200);
    chk("core win", {21'h0, 1'b1, 3'h7, 2'h0, 5'h09}, {21'h0, taken});
    rd_chk("pending", 8'h08, 32'h0000_0204);
    wr32(8'h04, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk("fwd masked", 32'h0000_0004, fwd);
    $display("test forward done");
  endtask : test_forward

  task automatic test_irq();
    wr32(8'h00, 32'h0000_0000);
    wr32(8'h10, 32'h0000_0003);
    wr32(8'h14, 32'h0000_0001);
    pulse(32'h0000_0080);
    chk("irq set", 32'h1, {31'h0, irq});
    rd_chk("evt stat", 8'h10, 32'h0000_0001);
    wr32(8'h10, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr32(8'h14, 32'h0000_0000);
    wr32(8'h00, 32'h0000_0000);
    pulse(32'h0000_0080);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    rd_chk("evt both", 8'h10, 32'h0000_0003);
    $display("test irq done");
  endtask : test_irq

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_reset();
    test_regs();
    test_levels();
    test_forward();
    test_irq();
    finish_test();
  end

  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #100us;
    fail_count++;
    finish_test();
  end
endmodule : tb

`default_nettype wire
